//--- vls_pkg.sv
// Behaviour
// - one select routes all four fast channels
// - separate select routes side lines
// - four fast channels handled identically
// - slave address fixed high bits plus strap
// - fast source switch drops chosen terminations 100 ms
// - termination off bit drops all inputs
// - per channel boost bit: 6 or 12 dB
// - one bit for all output terminations
// - enable bit tristates all fast outputs
// - current bit: 20 mA default, 10 mA
// - two bit pre-emphasis field for outputs
// - reset restores defaults, starts switching delay
// - settings apply at once, then hold for a per register delay
// - writes in window defer, last one wins
package vls_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_FAST   = 8'h00;
    localparam logic [7:0] IDX_SIDE   = 8'h01;
    localparam logic [7:0] IDX_RXSET  = 8'h10;
    localparam logic [7:0] IDX_PULSE  = 8'h11;
    localparam logic [7:0] IDX_BOOST  = 8'h12;
    localparam logic [7:0] IDX_TXSET  = 8'h20;
    localparam logic [7:0] IDX_STATUS = 8'h30;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_FAST  = 8'h40;
    localparam logic [7:0] RST_SIDE  = 8'h40;
    localparam logic [7:0] RST_RXSET = 8'h01;
    localparam logic [7:0] RST_PULSE = 8'h00;
    localparam logic [7:0] RST_BOOST = 8'h00;
    localparam logic [7:0] RST_TXSET = 8'h01;

    // writable slots, in order of the arrays below
    localparam int NSLOT      = 6;
    localparam int SLOT_FAST  = 0;
    localparam int SLOT_SIDE  = 1;
    localparam int SLOT_RXSET = 2;
    localparam int SLOT_PULSE = 3;
    localparam int SLOT_BOOST = 4;
    localparam int SLOT_TXSET = 5;
    localparam logic [NSLOT-1:0][7:0] SLOT_IDX =
        {IDX_TXSET, IDX_BOOST, IDX_PULSE, IDX_RXSET, IDX_SIDE, IDX_FAST};
    localparam logic [NSLOT-1:0][7:0] SLOT_RST =
        {RST_TXSET, RST_BOOST, RST_PULSE, RST_RXSET, RST_SIDE, RST_FAST};

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_SEL       = 0;
    localparam int BIT_EN        = 6;
    localparam int BIT_TERM_ON   = 0;
    localparam int BIT_OUT_TERM  = 0;
    localparam int BIT_LOW_CUR   = 1;
    localparam int BOOST_LSB     = 2;
    localparam int ST_FAST_SEL   = 0;
    localparam int ST_SIDE_SEL   = 1;
    localparam int ST_PULSE      = 2;
    localparam int ST_PEND       = 3;
    localparam int ST_ADDR_LSB   = 8;

    localparam logic [5:0] SLAVE_ADDR_HI = 6'h24;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned TERM_PULSE_MS   = 100;
    localparam int unsigned SWITCH_DELAY_US = 1;
    localparam int unsigned SETTING_DELAY_US = 1;
    localparam int unsigned TERM_PULSE_CYC  = TERM_PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned SWITCH_CYC      = SWITCH_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int unsigned SETTING_CYC     = SETTING_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int DLY_W = 16;

    // applied settings as seen by the analog side
    typedef struct packed {
        logic       fast_source_select;
        logic       fast_output_enable;
        logic       side_source_select;
        logic       side_enable;
        logic [7:0] in_term_en;
        logic [7:0] in_boost_bits;
        logic       out_term_on;
        logic       out_current_level;
        logic [1:0] out_boost_field;
    } vls_settings_s;

endpackage : vls_pkg

//--- vls_ctrl.sv
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module vls_ctrl #(
    parameter int unsigned PULSE_CYC  = vls_pkg::TERM_PULSE_CYC,
    parameter int unsigned SWITCH_DLY = vls_pkg::SWITCH_CYC,
    parameter int unsigned SET_DLY    = vls_pkg::SETTING_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [9:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    input  wire logic                   addr_sel_i,
    output logic [6:0]                  slave_addr_o,
    output vls_pkg::vls_settings_s      settings_o
);
    import vls_pkg::*;

    localparam int PW = $clog2(PULSE_CYC + 1);
    localparam logic [PW-1:0]    PULSE_LOAD = PW'(PULSE_CYC);
    localparam logic [DLY_W-1:0] SW_LOAD    = DLY_W'(SWITCH_DLY);
    localparam logic [DLY_W-1:0] SET_LOAD   = DLY_W'(SET_DLY);

    typedef struct packed {
        logic [NSLOT-1:0][7:0]       wr;
        logic [NSLOT-1:0][7:0]       ap;
        logic [NSLOT-1:0][DLY_W-1:0] cnt;
        logic [NSLOT-1:0]            pend;
        logic [PW-1:0]               pulse;
        logic                        ack;
        logic [31:0]                 rdat;
        logic                        sync1;
        logic                        sync2;
        logic [1:0]                  strap_cnt;
        logic                        addr_lsb;
        vls_settings_s               out;
    } vls_state_s;

    vls_state_s state_reg;
    vls_state_s state_next;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // source selects share the switching delay, the rest the setting delay
    function automatic logic [DLY_W-1:0] slot_delay(input int slot);
        slot_delay = (slot == SLOT_FAST || slot == SLOT_SIDE) ? SW_LOAD : SET_LOAD;
    endfunction : slot_delay

    function automatic vls_settings_s map_out(input logic [NSLOT-1:0][7:0] ap,
                                              input logic pulse_on);
        vls_settings_s s;
        logic [7:0]    drop;
        drop = pulse_on ? ap[SLOT_PULSE] : 8'h00;
        s.fast_source_select = ap[SLOT_FAST][BIT_SEL];
        s.fast_output_enable = ap[SLOT_FAST][BIT_EN];
        s.side_source_select = ap[SLOT_SIDE][BIT_SEL];
        s.side_enable        = ap[SLOT_SIDE][BIT_EN];
        // clearing the termination bit overrides every pulse bit
        s.in_term_en = ap[SLOT_RXSET][BIT_TERM_ON] ? ~drop : 8'h00;
        s.in_boost_bits      = ap[SLOT_BOOST];
        s.out_term_on        = ap[SLOT_TXSET][BIT_OUT_TERM];
        s.out_current_level  = ap[SLOT_TXSET][BIT_LOW_CUR];
        s.out_boost_field    = ap[SLOT_TXSET][BOOST_LSB +: 2];
        map_out = s;
    endfunction : map_out

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic       req;
    logic       wr_take;
    logic [7:0] idx;
    assign req     = wb_cyc_i & wb_stb_i;
    // a write lands at the edge where ack is high, as the master samples it
    assign wr_take = req & wb_we_i & state_reg.ack & wb_sel_i[0];
    assign idx     = wb_adr_i[9:2];

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic       hit;
        logic [7:0] rd;
        logic       any_pend;
        hit        = 1'b0;
        rd         = 8'h00;
        any_pend   = 1'b0;
        state_next = state_reg;

        // registered ack, one wait cycle, drops after one cycle
        state_next.ack = req & ~state_reg.ack;

        // per slot shadow, delay window and deferred apply
        for (int i = 0; i < NSLOT; i++) begin
            hit = wr_take && (idx == SLOT_IDX[i]);
            if (state_reg.cnt[i] != '0) begin
                state_next.cnt[i] = state_reg.cnt[i] - 1'b1;
            end
            if (hit) begin
                state_next.wr[i] = wb_dat_i[7:0];
                if (state_reg.cnt[i] == '0) begin
                    // idle window: apply at once and open a new window
                    state_next.ap[i]   = wb_dat_i[7:0];
                    state_next.cnt[i]  = slot_delay(i);
                    state_next.pend[i] = 1'b0;
                end else begin
                    // open window is not restarted
                    state_next.pend[i] = 1'b1;
                end
            end
            if (state_reg.cnt[i] == DLY_W'(1) && (state_reg.pend[i] || hit)) begin
                // window ends: the last value written takes effect
                state_next.ap[i]   = hit ? wb_dat_i[7:0] : state_reg.wr[i];
                state_next.pend[i] = 1'b0;
            end
            any_pend = any_pend | state_reg.pend[i];
        end

        // termination pulse timed by an internal down counter
        if (state_next.ap[SLOT_FAST][BIT_SEL] != state_reg.ap[SLOT_FAST][BIT_SEL]) begin
            state_next.pulse = PULSE_LOAD;
        end else if (state_reg.pulse != '0) begin
            state_next.pulse = state_reg.pulse - 1'b1;
        end

        // outputs from flops, built off the next applied state
        state_next.out = map_out(state_next.ap, state_next.pulse != '0);

        // strap synchroniser, captured once after reset release
        state_next.sync1 = addr_sel_i;
        state_next.sync2 = state_reg.sync1;
        if (state_reg.strap_cnt != 2'h3) begin
            state_next.strap_cnt = state_reg.strap_cnt + 2'h1;
        end
        if (state_reg.strap_cnt == 2'h2) begin
            state_next.addr_lsb = state_reg.sync2;
        end

        // read data, sampled when the request is first seen
        for (int i = 0; i < NSLOT; i++) begin
            if (idx == SLOT_IDX[i]) begin
                rd = state_reg.wr[i];
            end
        end
        if (req && !state_reg.ack) begin
            state_next.rdat = {24'h000000, rd};
            if (idx == IDX_STATUS) begin
                state_next.rdat                = 32'h00000000;
                state_next.rdat[ST_FAST_SEL]   = state_reg.ap[SLOT_FAST][BIT_SEL];
                state_next.rdat[ST_SIDE_SEL]   = state_reg.ap[SLOT_SIDE][BIT_SEL];
                state_next.rdat[ST_PULSE]      = state_reg.pulse != '0;
                state_next.rdat[ST_PEND]       = any_pend;
                state_next.rdat[ST_ADDR_LSB +: 7] = {SLAVE_ADDR_HI, state_reg.addr_lsb};
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // reset forces source A and opens the switching window
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg                 <= '0;
            state_reg.wr              <= SLOT_RST;
            state_reg.ap              <= SLOT_RST;
            state_reg.cnt[SLOT_FAST]  <= SW_LOAD;
            state_reg.out             <= map_out(SLOT_RST, 1'b0);
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign wb_dat_o     = state_reg.rdat;
    assign wb_ack_o     = state_reg.ack;
    assign slave_addr_o = {SLAVE_ADDR_HI, state_reg.addr_lsb};
    assign settings_o   = state_reg.out;

endmodule : vls_ctrl

//--- vls_link_model.sv
`timescale 1ns/1ps
// ------------------------------------------------
// far side: two cable sources and one receiver
// ------------------------------------------------
module vls_link_model (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire vls_pkg::vls_settings_s settings_i,
    output logic [1:0]                  route_o
);
    import vls_pkg::*;
    logic [3:0] word_ph;
    // each source shifts ten data bits per word clock period
    always @(posedge clk_i) begin
        word_ph <= (rst_i || word_ph == 4'h9) ? 4'h0 : word_ph + 4'h1;
    end
    // receiver sees source A (01), B (10), or nothing while tristated
    always_comb begin
        route_o = settings_i.fast_source_select ? 2'h2 : 2'h1;
        if (!settings_i.fast_output_enable) begin
            route_o = 2'h0;
        end
    end
endmodule : vls_link_model

//--- vls_ctrl_sva.sv
`timescale 1ns/1ps
// ------------------------------------------------
// control block port checks
// ------------------------------------------------
module vls_ctrl_sva #(
    parameter int unsigned PULSE_CYC  = 20,
    parameter int unsigned SWITCH_DLY = 4,
    parameter int unsigned SET_DLY    = 4
) (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic [31:0]            wb_dat_o,
    input wire logic                   wb_ack_o,
    input wire logic                   addr_sel_i,
    input wire logic [6:0]             slave_addr_o,
    input wire vls_pkg::vls_settings_s settings_o
);
    import vls_pkg::*;
    localparam int unsigned DLY = (SWITCH_DLY > SET_DLY) ? SWITCH_DLY : SET_DLY;
    logic [7:0]  quiet_cnt;
    logic [31:0] pulse_cnt;
    logic        fsel_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // cycles since last ack; length of a partial termination drop
    always_ff @(posedge clk_i) begin
        fsel_q <= settings_o.fast_source_select;
        if (rst_i) begin
            quiet_cnt <= 8'h00;
            pulse_cnt <= 32'h0;
        end else begin
            quiet_cnt <= wb_ack_o ? 8'h00 : quiet_cnt + {7'h0, quiet_cnt != 8'hFF};
            pulse_cnt <= (fsel_q != settings_o.fast_source_select) ? 32'h1 :
                         (settings_o.in_term_en != 8'hFF && settings_o.in_term_en != 8'h00)
                         ? pulse_cnt + 32'h1 : 32'h0;
        end
    end
    chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_dat_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
        else $error("read data moved without request");
    chk_addr_fixed: assert property (slave_addr_o[6:1] == SLAVE_ADDR_HI)
        else $error("slave address high bits wrong");
    chk_addr_strap: assert property ($stable(addr_sel_i)[*5] |-> slave_addr_o[0] == addr_sel_i)
        else $error("slave address lsb not strap");
    chk_reset_dflt: assert property ($fell(rst_i) |-> settings_o == 24'h5FF008 && !wb_ack_o)
        else $error("settings not default after reset");
    chk_term_drop: assert property ($fell(settings_o.in_term_en == 8'hFF)
        && settings_o.in_term_en != 8'h00 |-> $changed(settings_o.fast_source_select))
        else $error("termination drop without switch");
    chk_pulse_len: assert property (pulse_cnt <= PULSE_CYC + 1)
        else $error("termination drop too long");
    chk_hold_quiet: assert property (quiet_cnt > DLY + 2 |-> $stable({
        settings_o[23:20], settings_o[11:0]}))
        else $error("setting changed without write");
endmodule : vls_ctrl_sva

bind vls_ctrl vls_ctrl_sva #(
    .PULSE_CYC(PULSE_CYC), .SWITCH_DLY(SWITCH_DLY), .SET_DLY(SET_DLY)
) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .addr_sel_i(addr_sel_i),
    .slave_addr_o(slave_addr_o), .settings_o(settings_o)
);

//--- video_link_switch_control_tb_top.sv
`timescale 1ns/1ps
module video_link_switch_control_tb_top;
    import vls_pkg::*;
    localparam int unsigned PC = 20;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic addr_sel_i = 1'b1, wb_ack_o;
    logic [9:0]  wb_adr_i = 10'h000;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [6:0]  slave_addr_o;
    logic [1:0]  route;
    vls_settings_s settings_o;
    int n_mismatch = 0, samples_checked = 0;
    // ------------------------------------------------
    // clock, design and far side
    // ------------------------------------------------
    always #5 clk_i = ~clk_i;
    vls_ctrl #(.PULSE_CYC(PC), .SWITCH_DLY(4), .SET_DLY(4)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .addr_sel_i(addr_sel_i),
        .slave_addr_o(slave_addr_o), .settings_o(settings_o));
    vls_link_model u_link (.clk_i(clk_i), .rst_i(rst_i), .settings_i(settings_o), .route_o(route));
    // ------------------------------------------------
    // bus tasks and compare
    // ------------------------------------------------
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // one classic cycle; held until ack is sampled, bounded wait
    task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        for (n = 0; n < 20 && wb_ack_o !== 1'b1; n++) begin
            @(posedge clk_i);
        end
        if (wb_ack_o !== 1'b1) begin
            n_mismatch++;
            final_report();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : xfer
    // ------------------------------------------------
    // main sequence
    // ------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        #1 cmp(settings_o, 32'h5FF008);
        cmp(slave_addr_o, {SLAVE_ADDR_HI, 1'b1});
        for (int i = 0; i < NSLOT; i++) begin
            xfer(1'b0, SLOT_IDX[i], 8'h00);
            cmp(q, {24'h0, SLOT_RST[i]});
        end
        xfer(1'b0, 8'h3F, 8'h00);
        cmp(q, 32'h0);
        // switch to B: only the chosen inputs drop, then reconnect
        xfer(1'b1, IDX_PULSE, 8'hA5);
        xfer(1'b1, IDX_FAST, 8'h41);
        #1 cmp(route, 32'h2);
        cmp(settings_o.in_term_en, 32'h5A);
        repeat (PC - 2) @(posedge clk_i);
        #1 cmp(settings_o.in_term_en, 32'h5A);
        repeat (4) @(posedge clk_i);
        #1 cmp(settings_o.in_term_en, 32'hFF);
        xfer(1'b1, IDX_FAST, 8'h40);
        repeat (PC + 5) @(posedge clk_i);
        xfer(1'b1, IDX_RXSET, 8'h00);
        #1 cmp(settings_o.in_term_en, 32'h00);
        repeat (6) @(posedge clk_i);
        xfer(1'b1, IDX_RXSET, 8'h01);
        #1 cmp(settings_o.in_term_en, 32'hFF);
        xfer(1'b1, IDX_BOOST, 8'h3C);
        #1 cmp(settings_o.in_boost_bits, 32'h3C);
        // outputs off before any termination change, so no unterminated drive
        xfer(1'b1, IDX_FAST, 8'h00);
        #1 cmp(route, 32'h0);
        for (int i = 0; i < 4; i++) begin
            repeat (6) @(posedge clk_i);
            xfer(1'b1, IDX_TXSET, {4'h0, i[1:0], i[0], i[1]});
            #1 cmp(settings_o[3:0], {28'h0, i[1], i[0], i[1:0]});
        end
        // second write lands inside the window and waits for its end
        xfer(1'b1, IDX_SIDE, 8'h41);
        #1 cmp(settings_o.side_source_select, 32'h1);
        xfer(1'b1, IDX_SIDE, 8'h40);
        #1 cmp(settings_o.side_source_select, 32'h1);
        xfer(1'b0, IDX_SIDE, 8'h00);
        cmp(q, 32'h40);
        #1 cmp(settings_o.side_source_select, 32'h0);
        // mid-run reset: back to A, a fast-select write right after waits out the window
        xfer(1'b1, IDX_FAST, 8'h41);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        xfer(1'b1, IDX_FAST, 8'h41);
        #1 cmp(settings_o.fast_source_select, 32'h0);
        repeat (2) @(posedge clk_i);
        #1 cmp(settings_o.fast_source_select, 32'h1);
        final_report();
    end
endmodule : video_link_switch_control_tb_top
